// ---- pkg/lookup_regs.svh ----
// register indices, field positions, reset values and timing counts of the lookup status bank
`ifndef LOOKUP_REGS_SVH
`define LOOKUP_REGS_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define LKP_IDX_RD_LOWER 14'h1805
`define LKP_IDX_RD_UPPER 14'h1806
`define LKP_IDX_CMD_STS  14'h1808
`define LKP_IDX_AGE_CFG  14'h1809
`define LKP_IDX_IRQ_STS  14'h1820
`define LKP_IDX_IRQ_MSK  14'h1821

// ==========================================================
// field positions
`define UPR_VALID_BIT    24
`define UPR_END_BIT      23
`define UPR_STATIC_BIT   22
`define UPR_FILTER_BIT   21
`define UPR_PRIO_LSB     19
`define UPR_PORT_LSB     16
`define UPR_MAC_LSB      0
`define STS_INIT_BIT     1
`define STS_MAKE_BIT     0
`define CFG_AGE_TEST_BIT 0
`define IRQ_INIT_BIT     0
`define IRQ_SRCH_BIT     1
`define IRQ_MAKE_BIT     2
`define IRQ_W            3

// ==========================================================
// reset values
`define RST_WORD 32'h0000_0000
`define RST_IRQ  3'h0

// ==========================================================
// timing
`define CLK_PERIOD_NS     100
`define INIT_TIME_US      20
`define INIT_CYCLES       ((`INIT_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AGE_NORMAL_MIN    5
`define AGE_TEST_MS       50
`define AGE_NORMAL_CYCLES (64'(`AGE_NORMAL_MIN) * 64'd60000000000 / 64'(`CLK_PERIOD_NS))
`define AGE_TEST_CYCLES   (64'(`AGE_TEST_MS) * 64'd1000000 / 64'(`CLK_PERIOD_NS))

`endif

// ---- pkg/lookup_pkg.sv ----
// types shared by the lookup status bank and its aging timer
package lookup_pkg;

    typedef enum logic [0:0] {INIT_RUN, INIT_DONE} init_state_t;

    typedef struct packed {
        init_state_t init_st;
        logic [15:0] init_cnt;
        logic        init_done;
        logic        valid;
        logic        tbl_end;
        logic        ent_static;
        logic        ent_filter;
        logic [1:0]  ent_prio;
        logic [2:0]  ent_port;
        logic [47:0] mac;
        logic        make_pend;
        logic        age_test;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_msk;
        logic [31:0] rdata;
        logic        irq;
        logic        rx_drop;
        logic        prio_use;
        logic [1:0]  prio_val;
        logic        age_tick;
    } bank_state_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        mode;
        logic        tick;
    } timer_state_t;

endpackage : lookup_pkg

// ---- pkg/age_if.sv ----
// aging timer link between the status bank and its timer
`timescale 1ns/1ps

interface age_if;
    logic test_mode;
    logic tick;
    modport timer (input test_mode, output tick);
    modport user  (output test_mode, input tick);
endinterface : age_if

// ---- rtl/aging_timer.sv ----
// aging timer: one-cycle tick per aging period
`timescale 1ns/1ps

module aging_timer
#(
    parameter logic [31:0] NORMAL_CYCLES = 32'd100,
    parameter logic [31:0] TEST_CYCLES   = 32'd10
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    age_if.timer      age
);

    lookup_pkg::timer_state_t q;
    lookup_pkg::timer_state_t d;
    logic [31:0]              last;

    assign last    = (q.mode ? TEST_CYCLES : NORMAL_CYCLES) - 32'd1;
    assign age.tick = q.tick;

    // ==========================================================
    // period counter
    always_comb
    begin
        d      = q;
        d.tick = 1'b0;
        d.mode = age.test_mode;
        // mode change restarts the period so a short test never inherits a long count
        if (q.mode != age.test_mode)
        begin
            d.cnt = 32'd0;
        end
        else if (q.cnt >= last)
        begin
            d.cnt  = 32'd0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 32'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule : aging_timer

// ---- rtl/lookup_table_readback_status.sv ----
// lookup table readback, command status, aging and interrupt register bank
`timescale 1ns/1ps
`include "lookup_regs.svh"

// ==========================================================
// Notes on behaviour
// - a first or next search command clears the entry-valid flag.
// - a search that finds an entry sets valid and loads the entry.
// - a search reaching the table top without a find leaves valid clear.
// - table_walk_finished flag sets when the walk ends; valid may be either.
// - static shows aging exemption; others vanish after 5 to 10 idle minutes.
// - filter field means destination-matching packets are dropped.
// - entry priority used only for static entries with the override set.
// - three-bit port field; top bit set means several ports.
// - upper word low sixteen bits hold the last sixteen address bits.
// - after reset the table initialises for about 20 us, dropping packets.
// - init-complete reads 0 after reset and sets itself when done.
// - make-pending reads 1 while an add is in progress, then clears.
// - lower word holds the first 32 address bits, bit 0 multicast.
// - short aging test shrinks the aging period from 5 min to 50 ms.
module lookup_table_readback_status
#(
    parameter logic [31:0] AGE_NORMAL_CYCLES = 32'(`AGE_NORMAL_CYCLES),
    parameter logic [31:0] AGE_TEST_CYCLES   = 32'(`AGE_TEST_CYCLES)
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        search_first_req,
    input  wire logic        search_next_req,
    input  wire logic        srch_done,
    input  wire logic        srch_hit,
    input  wire logic        srch_end,
    input  wire logic        srch_static,
    input  wire logic        srch_filter,
    input  wire logic [1:0]  srch_prio,
    input  wire logic [2:0]  srch_port,
    input  wire logic [47:0] srch_mac,
    input  wire logic        make_req,
    input  wire logic        make_done,
    input  wire logic        dest_priority_override,
    input  wire logic        da_hit,
    input  wire logic        da_static,
    input  wire logic        da_filter,
    input  wire logic [1:0]  da_prio,
    output logic             rx_drop,
    output logic             da_prio_use,
    output logic      [1:0]  da_prio_out,
    output logic             age_tick,
    output logic             table_init_complete
);

    localparam logic [15:0] INIT_LAST = 16'(`INIT_CYCLES - 1);

    lookup_pkg::bank_state_t q;
    lookup_pkg::bank_state_t d;
    age_if                   age ();

    logic [13:0]       idx;
    logic              aligned;
    logic              rd_ok;
    logic              wr_ok;
    logic [`IRQ_W-1:0] ev;
    logic [31:0]       rword;

    assign idx     = reg_addr[15:2];
    assign aligned = (reg_addr[1:0] == 2'h0);
    assign rd_ok   = reg_rd && aligned;
    assign wr_ok   = reg_wr && aligned;

    assign age.test_mode = q.age_test;

    aging_timer
    #(
        .NORMAL_CYCLES (AGE_NORMAL_CYCLES),
        .TEST_CYCLES   (AGE_TEST_CYCLES)
    )
    u_timer
    (
        .clk   (clk),
        .rst_n (rst_n),
        .age   (age.timer)
    );

    // ==========================================================
    // read mux
    always_comb
    begin
        rword = `RST_WORD;
        case (idx)
            `LKP_IDX_RD_LOWER:
            begin
                rword = q.mac[31:0];
            end
            `LKP_IDX_RD_UPPER:
            begin
                rword[`UPR_VALID_BIT]       = q.valid;
                rword[`UPR_END_BIT]         = q.tbl_end;
                rword[`UPR_STATIC_BIT]      = q.ent_static;
                rword[`UPR_FILTER_BIT]      = q.ent_filter;
                rword[`UPR_PRIO_LSB +: 2]   = q.ent_prio;
                rword[`UPR_PORT_LSB +: 3]   = q.ent_port;
                rword[`UPR_MAC_LSB +: 16]   = q.mac[47:32];
            end
            `LKP_IDX_CMD_STS:
            begin
                rword[`STS_INIT_BIT] = q.init_done;
                rword[`STS_MAKE_BIT] = q.make_pend;
            end
            `LKP_IDX_AGE_CFG:
            begin
                rword[`CFG_AGE_TEST_BIT] = q.age_test;
            end
            `LKP_IDX_IRQ_STS:
            begin
                rword[`IRQ_W-1:0] = q.irq_sts;
            end
            `LKP_IDX_IRQ_MSK:
            begin
                rword[`IRQ_W-1:0] = q.irq_msk;
            end
            default:
            begin
                rword = `RST_WORD;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        d          = q;
        ev         = '0;
        d.age_tick = age.tick;
        d.rdata    = rd_ok ? rword : `RST_WORD;

        // table initialisation after reset
        case (q.init_st)
            lookup_pkg::INIT_RUN:
            begin
                if (q.init_cnt == INIT_LAST)
                begin
                    d.init_st           = lookup_pkg::INIT_DONE;
                    d.init_done         = 1'b1;
                    ev[`IRQ_INIT_BIT]   = 1'b1;
                end
                else
                begin
                    d.init_cnt = q.init_cnt + 16'h0001;
                end
            end
            lookup_pkg::INIT_DONE:
            begin
                d.init_done = 1'b1;
            end
            default:
            begin
                d.init_st = lookup_pkg::INIT_RUN;
            end
        endcase

        // search commands; a result in the same cycle wins over the clear
        if (search_first_req || search_next_req)
        begin
            d.valid   = 1'b0;
            d.tbl_end = 1'b0;
        end
        if (srch_done)
        begin
            d.valid             = srch_hit;
            d.tbl_end           = srch_end;
            ev[`IRQ_SRCH_BIT]   = 1'b1;
            if (srch_hit)
            begin
                d.ent_static = srch_static;
                d.ent_filter = srch_filter;
                d.ent_prio   = srch_prio;
                d.ent_port   = srch_port;
                d.mac        = srch_mac;
            end
        end

        // add-entry progress; a new request wins over completion
        if (make_done)
        begin
            d.make_pend       = 1'b0;
            ev[`IRQ_MAKE_BIT] = q.make_pend;
        end
        if (make_req)
        begin
            d.make_pend = 1'b1;
        end

        // register writes; read-only words ignore them
        if (wr_ok)
        begin
            case (idx)
                `LKP_IDX_AGE_CFG:
                begin
                    d.age_test = reg_wdata[`CFG_AGE_TEST_BIT];
                end
                `LKP_IDX_IRQ_STS:
                begin
                    d.irq_sts = q.irq_sts & ~reg_wdata[`IRQ_W-1:0];
                end
                `LKP_IDX_IRQ_MSK:
                begin
                    d.irq_msk = reg_wdata[`IRQ_W-1:0];
                end
                default:
                begin
                    d.irq_msk = q.irq_msk;
                end
            endcase
        end
        d.irq_sts = d.irq_sts | ev;
        d.irq     = |(d.irq_sts & d.irq_msk);

        // forwarding decisions for the current destination lookup
        d.rx_drop  = (q.init_st == lookup_pkg::INIT_RUN)
                     || (da_hit && da_filter);
        d.prio_use = da_hit && da_static && dest_priority_override;
        d.prio_val = d.prio_use ? da_prio : 2'h0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q         <= '0;
            q.init_st <= lookup_pkg::INIT_RUN;
            q.rx_drop <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata           = q.rdata;
    assign irq                 = q.irq;
    assign rx_drop             = q.rx_drop;
    assign da_prio_use         = q.prio_use;
    assign da_prio_out         = q.prio_val;
    assign age_tick            = q.age_tick;
    assign table_init_complete = q.init_done;

    // ==========================================================
    // checks
    logic [15:0] cyc_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_q <= 16'h0000;
        end
        else if (cyc_q <= INIT_LAST)
        begin
            cyc_q <= cyc_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_SEARCH_CLEARS_VALID: assert property (
        (search_first_req || search_next_req) && !srch_done |=> !q.valid)
        else $error("search command did not clear valid");

    AST_HIT_LOADS_ENTRY: assert property (
        srch_done && srch_hit |=> q.valid && q.mac == $past(srch_mac)
                                  && q.ent_port == $past(srch_port))
        else $error("search hit not loaded");

    AST_MISS_LEAVES_CLEAR: assert property (
        srch_done && !srch_hit |=> !q.valid)
        else $error("valid set on miss");

    AST_TABLE_WALK_FINISHED: assert property (
        srch_done && srch_end ##1 !(search_first_req || search_next_req || srch_done)
        |-> q.tbl_end)
        else $error("table_walk_finished flag lost");

    AST_UPPER_LAYOUT: assert property (
        reg_rd && reg_addr == {`LKP_IDX_RD_UPPER, 2'h0}
        |=> reg_rdata[15:0] == $past(q.mac[47:32]) && reg_rdata[24] == $past(q.valid)
            && reg_rdata[31:25] == 7'h00)
        else $error("upper word layout wrong");

    AST_LOWER_WORD: assert property (
        reg_rd && reg_addr == {`LKP_IDX_RD_LOWER, 2'h0}
        |=> reg_rdata == $past(q.mac[31:0]))
        else $error("lower word wrong");

    AST_INIT_TIMING: assert property (
        table_init_complete == (cyc_q > INIT_LAST))
        else $error("init complete at wrong time");

    AST_INIT_DROPS: assert property (
        !table_init_complete |=> rx_drop)
        else $error("packet not dropped during init");

    AST_MAKE_PENDING: assert property (
        make_req |=> q.make_pend)
        else $error("make pending not set");

    AST_MAKE_CLEARS: assert property (
        make_done && !make_req |=> !q.make_pend)
        else $error("make pending not cleared");

    AST_FILTER_DROP: assert property (
        da_hit && da_filter |=> rx_drop)
        else $error("filtered packet not dropped");

    AST_PRIO_GATED: assert property (
        !(da_hit && da_static && dest_priority_override) |=> !da_prio_use
                                                             && da_prio_out == 2'h0)
        else $error("priority applied without override");

    AST_RO_STATUS: assert property (
        reg_rd && reg_addr == {`LKP_IDX_CMD_STS, 2'h0} |=> reg_rdata[31:2] == 30'h0)
        else $error("reserved status bits set");

    COV_SEARCH_HIT: cover property (srch_done && srch_hit ##1 q.valid);
    COV_WALK_END: cover property (srch_done && srch_end && !srch_hit);
    COV_MAKE: cover property (make_req ##[1:20] make_done);
    COV_IRQ: cover property (irq ##[1:10] !irq);

endmodule : lookup_table_readback_status

// ---- verif/tb.sv ----
// self-checking bench for the lookup table readback and status bank
`timescale 1ns/1ps
`include "lookup_regs.svh"

module tb;
    // ==========================================================
    // set-up
    localparam logic [31:0] NORM_CYC = 32'h0000_00C8;
    localparam logic [31:0] TEST_CYC = 32'h0000_0014;
    localparam logic [15:0] A_LOW    = {`LKP_IDX_RD_LOWER, 2'b00};
    localparam logic [15:0] A_UPR    = {`LKP_IDX_RD_UPPER, 2'b00};
    localparam logic [15:0] A_STS    = {`LKP_IDX_CMD_STS, 2'b00};
    localparam logic [15:0] A_CFG    = {`LKP_IDX_AGE_CFG, 2'b00};
    localparam logic [15:0] A_IST    = {`LKP_IDX_IRQ_STS, 2'b00};
    localparam logic [15:0] A_MSK    = {`LKP_IDX_IRQ_MSK, 2'b00};

    logic        clk, rst_n, reg_wr, reg_rd, irq, search_first_req, search_next_req;
    logic        srch_done, srch_hit, srch_end, srch_static, srch_filter, make_req, make_done;
    logic        dest_priority_override, da_hit, da_static, da_filter, rx_drop, da_prio_use;
    logic        age_tick, table_init_complete;
    logic [1:0]  srch_prio, da_prio, da_prio_out;
    logic [2:0]  srch_port;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cyc, d;
    logic [47:0] srch_mac, m;
    int          num_errors, checked;

    lookup_table_readback_status
    #(
        .AGE_NORMAL_CYCLES (NORM_CYC),
        .AGE_TEST_CYCLES   (TEST_CYC)
    )
    dut
    (
        .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .search_first_req, .search_next_req, .srch_done, .srch_hit, .srch_end,
        .srch_static, .srch_filter, .srch_prio, .srch_port, .srch_mac, .make_req, .make_done,
        .dest_priority_override, .da_hit, .da_static, .da_filter, .da_prio, .rx_drop,
        .da_prio_use, .da_prio_out, .age_tick, .table_init_complete
    );

    always #50 clk = ~clk;

    // edges since reset release, to time the table initialisation
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            cyc <= 32'h0000_0000;
        else
            cyc <= cyc + 32'h0000_0001;

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v;
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic req(input logic nxt);
        @(posedge clk);
        if (nxt)
            search_next_req <= 1'b1;
        else
            search_first_req <= 1'b1;
        @(posedge clk);
        search_next_req  <= 1'b0;
        search_first_req <= 1'b0;
        #1;
    endtask : req

    // result fields are only meaningful beside the done strobe
    task automatic srch(input logic hit, input logic fin, input logic [2:0] p,
                        input logic [47:0] mv);
        @(posedge clk);
        srch_done   <= 1'b1;
        srch_hit    <= hit;
        srch_end    <= fin;
        srch_static <= p[0];
        srch_filter <= p[1];
        srch_prio   <= p[1:0];
        srch_port   <= p;
        srch_mac    <= mv;
        @(posedge clk);
        srch_done <= 1'b0;
        srch_hit  <= ~hit;
        srch_end  <= ~fin;
        srch_port <= ~p;
        srch_mac  <= ~mv;
        #1;
    endtask : srch

    task automatic age_gap(input logic [31:0] exp);
        logic [31:0] n;
        n = 32'h0000_0000;
        while (age_tick !== 1'b1 && n < 32'h0000_03E8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 32'h0000_0000;
        do
        begin
            @(posedge clk);
            #1;
            n++;
            if (n == 32'h0000_0001)
                chk(age_tick, 1'b0, "tick is one cycle");
        end
        while (age_tick !== 1'b1 && n < 32'h0000_03E8);
        chk(n, exp, "aging period");
    endtask : age_gap

    function automatic logic [31:0] upr(input logic v, input logic e, input logic [2:0] p,
                                        input logic [47:0] mv);
        return {7'h00, v, e, p[0], p[1], p[1:0], p, mv[47:32]};
    endfunction : upr

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial
    begin
        #2000000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    // ==========================================================
    // tests
    initial
    begin
        {clk, rst_n, reg_wr, reg_rd, search_first_req, search_next_req, srch_done} = '0;
        {srch_hit, srch_end, srch_static, srch_filter, make_req, make_done} = '0;
        {dest_priority_override, da_hit, da_static, da_filter, da_prio} = '0;
        {srch_prio, srch_port, srch_mac, reg_addr, reg_wdata} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_STS, d);
        chk(d, 32'h0000_0000, "status right after reset");
        chk(rx_drop, 1'b1, "drop during init");
        rd(A_UPR, d);
        chk(d, `RST_WORD, "upper word reset value");
        while (table_init_complete !== 1'b1 && cyc < 32'h0000_0190)
        begin
            @(posedge clk);
            #1;
        end
        chk(cyc, `INIT_CYCLES, "init length");
        chk(rx_drop, 1'b1, "drop until init ends");
        @(posedge clk);
        #1;
        chk(rx_drop, 1'b0, "no drop after init");
        rd(A_STS, d);
        chk(d, 32'h0000_0002, "init done status");
        $display("test init done");

        rd(A_IST, d);
        chk(d, 32'h0000_0001, "init event pending");
        chk(irq, 1'b0, "masked event quiet");
        wr(A_MSK, 32'hFFFF_FFFF);
        rd(A_MSK, d);
        chk(d, 32'h0000_0007, "mask width");
        chk(irq, 1'b1, "unmasked event raises irq");
        wr(A_IST, 32'h0000_0001);
        rd(A_IST, d);
        chk(d, 32'h0000_0000, "write one clears");
        chk(irq, 1'b0, "irq drops after clear");
        wr(A_MSK, 32'h0000_0000);
        $display("test interrupt done");

        for (int i = 0; i < 8; i++)
        begin
            m = 48'h8421_C3E1_0F69 ^ {16{3'(i)}};
            req(i[0]);
            rd(A_UPR, d);
            chk(d[24:23], 2'h0, "request clears flags");
            srch(1'b1, 1'b0, 3'(i), m);
            rd(A_UPR, d);
            chk(d, upr(1'b1, 1'b0, 3'(i), m), "upper on hit");
            rd(A_LOW, d);
            chk(d, m[31:0], "lower on hit");
        end
        req(1'b1);
        srch(1'b0, 1'b1, 3'h0, ~m);
        rd(A_UPR, d);
        chk(d, upr(1'b0, 1'b1, 3'h7, m), "walk ends with no find");
        // walk is over, so a new walk starts with a first-entry search
        req(1'b0);
        srch(1'b1, 1'b1, 3'h5, ~m);
        rd(A_UPR, d);
        chk(d, upr(1'b1, 1'b1, 3'h5, ~m), "walk ends on a find");
        rd(A_IST, d);
        chk(d, 32'h0000_0002, "search event");
        wr(A_IST, 32'h0000_0007);
        $display("test search done");

        @(posedge clk);
        make_req <= 1'b1;
        @(posedge clk);
        make_req <= 1'b0;
        rd(A_STS, d);
        chk(d, 32'h0000_0003, "add pending");
        @(posedge clk);
        make_done <= 1'b1;
        @(posedge clk);
        make_done <= 1'b0;
        rd(A_STS, d);
        chk(d, 32'h0000_0002, "add finished");
        rd(A_IST, d);
        chk(d, 32'h0000_0004, "add event");
        wr(A_IST, 32'h0000_0007);
        $display("test add done");

        wr(A_UPR, 32'hFFFF_FFFF);
        wr(A_STS, 32'hFFFF_FFFF);
        wr(A_CFG + 16'h0002, 32'hFFFF_FFFF);
        rd(A_UPR, d);
        chk(d, upr(1'b1, 1'b1, 3'h5, ~m), "upper ignores writes");
        rd(A_STS, d);
        chk(d, 32'h0000_0002, "status ignores writes");
        rd(A_CFG, d);
        chk(d, 32'h0000_0000, "misaligned write ignored");
        rd(A_UPR + 16'h0001, d);
        chk(d, 32'h0000_0000, "misaligned read");
        rd(16'h601C, d);
        chk(d, 32'h0000_0000, "unmapped read");
        $display("test read-only done");

        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            {da_hit, da_static, da_filter, dest_priority_override} <= 4'(i);
            da_prio <= 2'(i + 1);
            repeat (2) @(posedge clk);
            #1;
            chk(rx_drop, i[3] & i[1], "filter drop");
            chk(da_prio_use, i[3] & i[2] & i[0], "priority use");
            chk(da_prio_out, (i[3] & i[2] & i[0]) ? 2'(i + 1) : 2'h0, "priority");
        end
        da_hit <= 1'b0;
        $display("test lookup decisions done");

        age_gap(NORM_CYC);
        wr(A_CFG, 32'hFFFF_FFFF);
        rd(A_CFG, d);
        chk(d, 32'h0000_0001, "config reserved bits");
        age_gap(TEST_CYC);
        $display("test aging done");
        summarize();
    end
endmodule : tb
